// [common/nvm_ctrl_params.svh]
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 8-bit special function register bus
// Notes:   Included by its bare name
`ifndef NVM_CTRL_PARAMS_SVH
`define NVM_CTRL_PARAMS_SVH

`define NVM_OFS_ADDRESS   8'hC6
`define NVM_OFS_KEY       8'hC7
`define NVM_OFS_CONTROL   8'hCE
`define NVM_OFS_WDATA     8'hCF
`define NVM_BIT_ERASE     7
`define NVM_BIT_WRITE     6
`define NVM_KEY_FIRST     8'hAA
`define NVM_KEY_SECOND    8'h55
`define NVM_RST_BYTE      8'h00
`define NVM_PAGE_COUNT    4
`define NVM_PAGE_BYTES    64
`define NVM_ERASED_BYTE   8'hFF
`define NVM_WINDOW_CYCLES 3
`define NVM_BUSY_WIDTH    8
`define NVM_ERASE_CYCLES  8'h40
`define NVM_WRITE_CYCLES  8'h08

`endif

// [common/nvm_ctrl_pkg.sv]
// Purpose: Shared types of the non-volatile data controller
// Assumes: Constants come from nvm_ctrl_params.svh
// Notes:   Types only
`default_nettype none
package nvm_ctrl_pkg;
    typedef enum logic [1:0] {
        OP_IDLE,
        OP_ERASE,
        OP_WRITE
    } op_e;
    typedef enum logic [1:0] {
        KEY_IDLE,
        KEY_ARMED,
        KEY_OPEN
    } key_e;
    typedef logic [7:0] byte_t;
    typedef logic [1:0] page_t;
endpackage
`default_nettype wire

// [common/nvm_array_if.sv]
// Purpose: Carries array commands from controller to storage
// Assumes: One clock domain
// Notes:   Erase and write are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
interface nvm_array_if;
    logic                erase;
    logic                write;
    nvm_ctrl_pkg::byte_t addr;
    nvm_ctrl_pkg::byte_t wdata;
    nvm_ctrl_pkg::byte_t rdata;
    modport ctrl (output erase, output write, output addr, output wdata,
                  input rdata);
    modport mem  (input erase, input write, input addr, input wdata,
                  output rdata);
endinterface
`default_nettype wire

// [logic/nvm_array.sv]
// Purpose: Flip-flop storage of four pages of 64 bytes
// Assumes: Commands come as one-cycle pulses
// Notes:   Erase fills the page with the erased value
`timescale 1ns/1ps
`default_nettype none
`include "nvm_ctrl_params.svh"
module nvm_array (
    // Clock and reset
    input  wire logic clock_in,
    input  wire logic rst_in,
    // Command side
    nvm_array_if.mem  port_if
);
    localparam int DEPTH = `NVM_PAGE_COUNT * `NVM_PAGE_BYTES;
    typedef struct packed {
        logic [DEPTH-1:0][7:0] mem;
    } state_s;
    state_s st_r;
    state_s st_nxt;
    nvm_ctrl_pkg::page_t pg;

    always_comb begin
        st_nxt = st_r;
        pg = port_if.addr[7:6];
        for (int i = 0; i < DEPTH; i++) begin
            // Erase picks the page from the two upper address bits
            if (port_if.erase && (i / `NVM_PAGE_BYTES) == int'(pg)) begin
                st_nxt.mem[i] = `NVM_ERASED_BYTE;
            end
        end
        if (port_if.write) begin
            st_nxt.mem[port_if.addr] = port_if.wdata;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            st_r <= '{mem: {DEPTH{`NVM_ERASED_BYTE}}};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign port_if.rdata = st_r.mem[port_if.addr];
endmodule // nvm_array
`default_nettype wire

// [logic/nvm_key_unlock.sv]
// Purpose: Timed-access unlock sequence for protected bits
// Assumes: One clock cycle per machine cycle
// Notes:   Any other write between the two keys restarts the sequence
`timescale 1ns/1ps
`default_nettype none
`include "nvm_ctrl_params.svh"
module nvm_key_unlock (
    // Clock and reset
    input  wire logic                clock_in,
    input  wire logic                rst_in,
    // Bus observation
    input  wire logic                wr_in,
    input  wire logic                key_hit_in,
    input  wire nvm_ctrl_pkg::byte_t wdata_in,
    // Window
    output logic                     open_out
);
    typedef struct packed {
        nvm_ctrl_pkg::key_e st;
        logic [1:0]         cnt;
    } state_s;
    state_s st_r;
    state_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        unique case (st_r.st)
            nvm_ctrl_pkg::KEY_IDLE: begin
                if (wr_in && key_hit_in && wdata_in == `NVM_KEY_FIRST) begin
                    st_nxt.st = nvm_ctrl_pkg::KEY_ARMED;
                end
            end
            nvm_ctrl_pkg::KEY_ARMED: begin
                if (wr_in) begin
                    if (key_hit_in && wdata_in == `NVM_KEY_SECOND) begin
                        st_nxt.st  = nvm_ctrl_pkg::KEY_OPEN;
                        st_nxt.cnt = 2'(`NVM_WINDOW_CYCLES - 1);
                    end else begin
                        st_nxt.st = nvm_ctrl_pkg::KEY_IDLE;
                    end
                end
            end
            nvm_ctrl_pkg::KEY_OPEN: begin
                if (st_r.cnt == 2'h0) begin
                    st_nxt.st = nvm_ctrl_pkg::KEY_IDLE;
                end else begin
                    st_nxt.cnt = st_r.cnt - 2'h1;
                end
            end
            default: st_nxt.st = nvm_ctrl_pkg::KEY_IDLE;
        endcase
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            st_r <= '{st: nvm_ctrl_pkg::KEY_IDLE, cnt: 2'h0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign open_out = (st_r.st == nvm_ctrl_pkg::KEY_OPEN);

    AST_WINDOW_THREE: assert property (
        @(posedge clock_in) disable iff (rst_in)
        $rose(open_out) |-> open_out [*3] ##1 !open_out)
        else $error("window not three cycles");
    AST_NO_OPEN_BAD: assert property (
        @(posedge clock_in) disable iff (rst_in)
        (st_r.st == nvm_ctrl_pkg::KEY_ARMED && wr_in &&
         !(key_hit_in && wdata_in == `NVM_KEY_SECOND)) |=> !open_out)
        else $error("window opened after wrong key");
endmodule // nvm_key_unlock
`default_nettype wire

// [logic/nvm_page_erase_byte_write_ctrl.sv]
// Purpose: Non-volatile data area controller: page erase and byte write
// Assumes: Plain register port, read data one cycle after the strobe
// Notes:   Start bits are protected and need the timed-access window
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "nvm_ctrl_params.svh"
module nvm_page_erase_byte_write_ctrl (
    // Clock and reset
    input  wire logic       clock_in,
    input  wire logic       rst_in,
    // Register port
    input  wire logic [7:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic       reg_wr_in,
    input  wire logic       reg_rd_in,
    output logic      [7:0] reg_rdata_out,
    // Code-memory read of the data area
    input  wire logic [7:0] code_addr_in,
    output logic      [7:0] code_rdata_out,
    // Processor stall
    output logic            cpu_stall_out
);
    //--------------------------------------------------------------
    // Decoding
    //--------------------------------------------------------------
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        return a == o;
    endfunction

    typedef struct packed {
        nvm_ctrl_pkg::op_e   op;
        logic [`NVM_BUSY_WIDTH-1:0] busy;
        nvm_ctrl_pkg::byte_t addr;
        nvm_ctrl_pkg::byte_t wdata;
        logic                erase_bit;
        logic                write_bit;
        logic                stall;
        logic                go_erase;
        logic                go_write;
        nvm_ctrl_pkg::byte_t rdata;
        nvm_ctrl_pkg::byte_t code_rdata;
    } state_s;
    state_s st_r;
    state_s st_nxt;

    logic window_open;
    logic ctl_wr;
    logic key_hit;
    nvm_array_if arr_if ();

    assign key_hit = hit(reg_addr_in, `NVM_OFS_KEY);
    assign ctl_wr  = reg_wr_in && hit(reg_addr_in, `NVM_OFS_CONTROL);

    //--------------------------------------------------------------
    // Submodules
    //--------------------------------------------------------------
    nvm_key_unlock u_key (
        .clock_in   (clock_in),
        .rst_in     (rst_in),
        .wr_in      (reg_wr_in),
        .key_hit_in (key_hit),
        .wdata_in   (reg_wdata_in),
        .open_out   (window_open)
    );

    nvm_array u_array (
        .clock_in (clock_in),
        .rst_in   (rst_in),
        .port_if  (arr_if)
    );

    // Address is frozen during an operation so the target cannot move
    assign arr_if.erase = st_r.go_erase;
    assign arr_if.write = st_r.go_write;
    assign arr_if.addr  = (st_r.op == nvm_ctrl_pkg::OP_IDLE) ?
                          code_addr_in : st_r.addr;
    assign arr_if.wdata = st_r.wdata;

    //--------------------------------------------------------------
    // Next state
    //--------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.go_erase = 1'b0;
        st_nxt.go_write = 1'b0;
        st_nxt.code_rdata = arr_if.rdata;
        if (reg_wr_in && st_r.op == nvm_ctrl_pkg::OP_IDLE) begin
            if (hit(reg_addr_in, `NVM_OFS_ADDRESS)) begin
                st_nxt.addr = reg_wdata_in;
            end
            if (hit(reg_addr_in, `NVM_OFS_WDATA)) begin
                st_nxt.wdata = reg_wdata_in;
            end
        end
        unique case (st_r.op)
            nvm_ctrl_pkg::OP_IDLE: begin
                // Start bits ignored outside the window
                if (ctl_wr && window_open) begin
                    if (reg_wdata_in[`NVM_BIT_ERASE]) begin
                        st_nxt.op = nvm_ctrl_pkg::OP_ERASE;
                        st_nxt.erase_bit = 1'b1;
                        st_nxt.busy = `NVM_ERASE_CYCLES;
                        st_nxt.stall = 1'b1;
                        st_nxt.go_erase = 1'b1;
                    end else if (reg_wdata_in[`NVM_BIT_WRITE]) begin
                        st_nxt.op = nvm_ctrl_pkg::OP_WRITE;
                        st_nxt.write_bit = 1'b1;
                        st_nxt.busy = `NVM_WRITE_CYCLES;
                        st_nxt.stall = 1'b1;
                        st_nxt.go_write = 1'b1;
                    end
                end
            end
            nvm_ctrl_pkg::OP_ERASE,
            nvm_ctrl_pkg::OP_WRITE: begin
                if (st_r.busy == `NVM_BUSY_WIDTH'(1)) begin
                    st_nxt.op = nvm_ctrl_pkg::OP_IDLE;
                    st_nxt.erase_bit = 1'b0;
                    st_nxt.write_bit = 1'b0;
                    st_nxt.stall = 1'b0;
                end else begin
                    st_nxt.busy = st_r.busy - `NVM_BUSY_WIDTH'(1);
                end
            end
            default: st_nxt.op = nvm_ctrl_pkg::OP_IDLE;
        endcase
        st_nxt.rdata = `NVM_RST_BYTE;
        if (reg_rd_in) begin
            if (hit(reg_addr_in, `NVM_OFS_ADDRESS)) begin
                st_nxt.rdata = st_r.addr;
            end else if (hit(reg_addr_in, `NVM_OFS_CONTROL)) begin
                st_nxt.rdata = {st_r.erase_bit, st_r.write_bit, 6'h00};
            end else if (hit(reg_addr_in, `NVM_OFS_WDATA)) begin
                st_nxt.rdata = st_r.wdata;
            end
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            st_r <= '{op: nvm_ctrl_pkg::OP_IDLE, busy: '0,
                      addr: `NVM_RST_BYTE, wdata: `NVM_RST_BYTE,
                      erase_bit: 1'b0, write_bit: 1'b0, stall: 1'b0,
                      go_erase: 1'b0, go_write: 1'b0,
                      rdata: `NVM_RST_BYTE, code_rdata: `NVM_RST_BYTE};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata_out  = st_r.rdata;
    assign code_rdata_out = st_r.code_rdata;
    assign cpu_stall_out  = st_r.stall;

    //--------------------------------------------------------------
    // Checks: bus decodes
    //--------------------------------------------------------------
    // Decoded apart from the next-state logic so its faults show
    logic addr_rd;
    logic ctrl_rd;
    logic wdata_rd;
    logic wdata_wr;
    logic key_rd;
    logic idle_now;

    assign addr_rd  = reg_rd_in && hit(reg_addr_in, `NVM_OFS_ADDRESS);
    assign ctrl_rd  = reg_rd_in && hit(reg_addr_in, `NVM_OFS_CONTROL);
    assign wdata_rd = reg_rd_in && hit(reg_addr_in, `NVM_OFS_WDATA);
    assign wdata_wr = reg_wr_in && hit(reg_addr_in, `NVM_OFS_WDATA);
    assign key_rd   = reg_rd_in && key_hit;
    assign idle_now = (st_r.op == nvm_ctrl_pkg::OP_IDLE);

    sequence s_start_erase;
        ctl_wr && window_open && idle_now && reg_wdata_in[`NVM_BIT_ERASE];
    endsequence
    sequence s_start_write;
        ctl_wr && window_open && idle_now &&
        !reg_wdata_in[`NVM_BIT_ERASE] && reg_wdata_in[`NVM_BIT_WRITE];
    endsequence
    sequence s_both_bits;
        ctl_wr && window_open && idle_now &&
        reg_wdata_in[`NVM_BIT_ERASE] && reg_wdata_in[`NVM_BIT_WRITE];
    endsequence
    sequence s_no_bits;
        ctl_wr && window_open && idle_now &&
        !reg_wdata_in[`NVM_BIT_ERASE] && !reg_wdata_in[`NVM_BIT_WRITE];
    endsequence
    sequence s_locked_ctrl;
        ctl_wr && !window_open && idle_now;
    endsequence
    // Eight stalled cycles of a byte write, then release
    sequence s_write_busy;
        cpu_stall_out [*8] ##1 !cpu_stall_out;
    endsequence

    //--------------------------------------------------------------
    // Checks: starting an operation
    //--------------------------------------------------------------
    AST_ERASE_STALL: assert property (
        @(posedge clock_in) disable iff (rst_in)
        s_start_erase |=> cpu_stall_out && arr_if.erase)
        else $error("erase did not start");

    AST_WRITE_STALL: assert property (
        @(posedge clock_in) disable iff (rst_in)
        s_start_write |=> cpu_stall_out && arr_if.write)
        else $error("write did not start");

    // Both bits at once run the erase only
    AST_BOTH_ERASE: assert property (
        @(posedge clock_in) disable iff (rst_in)
        s_both_bits |=> st_r.erase_bit && !st_r.write_bit &&
        arr_if.erase && !arr_if.write)
        else $error("both bits did not pick erase");

    AST_NO_STALL_ZERO: assert property (
        @(posedge clock_in) disable iff (rst_in)
        s_no_bits |=> !cpu_stall_out)
        else $error("stall without a start bit");

    AST_LOCKED: assert property (
        @(posedge clock_in) disable iff (rst_in)
        s_locked_ctrl |=> !cpu_stall_out)
        else $error("locked start accepted");

    AST_STALL_RISE: assert property (
        @(posedge clock_in) disable iff (rst_in)
        $rose(cpu_stall_out) |-> $past(ctl_wr && window_open))
        else $error("stall rose without unlocked start");

    //--------------------------------------------------------------
    // Checks: completion
    //--------------------------------------------------------------
    AST_ERASE_DONE: assert property (
        @(posedge clock_in) disable iff (rst_in)
        s_start_erase |-> ##[1:70] (!cpu_stall_out && !st_r.erase_bit))
        else $error("erase never completed");

    // Too long for a repetition; the last stalled cycle and the release are checked
    AST_ERASE_LENGTH: assert property (
        @(posedge clock_in) disable iff (rst_in)
        s_start_erase |-> ##64 cpu_stall_out ##1 !cpu_stall_out)
        else $error("erase stall length wrong");

    AST_WRITE_DONE: assert property (
        @(posedge clock_in) disable iff (rst_in)
        s_start_write |-> ##9 (!cpu_stall_out && !st_r.write_bit))
        else $error("write length wrong");

    AST_WRITE_LENGTH: assert property (
        @(posedge clock_in) disable iff (rst_in)
        s_start_write |=> s_write_busy)
        else $error("write stall not continuous");

    AST_CTRL_CLEAR: assert property (
        @(posedge clock_in) disable iff (rst_in)
        $fell(cpu_stall_out) |-> !st_r.erase_bit && !st_r.write_bit)
        else $error("start bit left set after release");

    //--------------------------------------------------------------
    // Checks: array commands
    //--------------------------------------------------------------
    AST_NO_ERASE: assert property (
        @(posedge clock_in) disable iff (rst_in)
        arr_if.erase |-> $past(st_nxt.erase_bit) && st_r.erase_bit)
        else $error("erase without erase bit");

    AST_NO_WRITE: assert property (
        @(posedge clock_in) disable iff (rst_in)
        arr_if.write |-> st_r.write_bit)
        else $error("write without write bit");

    AST_ONE_COMMAND: assert property (
        @(posedge clock_in) disable iff (rst_in)
        !(arr_if.erase && arr_if.write))
        else $error("erase and write together");

    AST_PULSE_AT_START: assert property (
        @(posedge clock_in) disable iff (rst_in)
        (arr_if.erase || arr_if.write) |->
        cpu_stall_out && !$past(cpu_stall_out))
        else $error("array command outside first stall cycle");

    AST_ARRAY_TARGET: assert property (
        @(posedge clock_in) disable iff (rst_in)
        (arr_if.erase || arr_if.write) |-> arr_if.addr == st_r.addr)
        else $error("array command at wrong address");

    AST_ADDR_HOLD: assert property (
        @(posedge clock_in) disable iff (rst_in)
        cpu_stall_out && $past(cpu_stall_out) |-> $stable(st_r.addr))
        else $error("address moved during operation");

    AST_BUSY_NO_LOAD: assert property (
        @(posedge clock_in) disable iff (rst_in)
        (!idle_now && wdata_wr) |=> $stable(st_r.wdata))
        else $error("data register loaded during operation");

    //--------------------------------------------------------------
    // Checks: register reads
    //--------------------------------------------------------------
    AST_ADDR_READ: assert property (
        @(posedge clock_in) disable iff (rst_in)
        addr_rd |=> reg_rdata_out == $past(st_r.addr))
        else $error("address read wrong");

    AST_WDATA_READ: assert property (
        @(posedge clock_in) disable iff (rst_in)
        wdata_rd |=> reg_rdata_out == $past(st_r.wdata))
        else $error("data register read wrong");

    AST_CTRL_READ: assert property (
        @(posedge clock_in) disable iff (rst_in)
        ctrl_rd |=> reg_rdata_out ==
        {$past(st_r.erase_bit), $past(st_r.write_bit), 6'h00})
        else $error("control read wrong");

    AST_KEY_READ: assert property (
        @(posedge clock_in) disable iff (rst_in)
        key_rd |=> reg_rdata_out == `NVM_RST_BYTE)
        else $error("key register read not zero");

    AST_RDATA_ONE: assert property (
        @(posedge clock_in) disable iff (rst_in)
        !reg_rd_in |=> reg_rdata_out == `NVM_RST_BYTE)
        else $error("read data stood too long");
endmodule // nvm_page_erase_byte_write_ctrl
`default_nettype wire

// [test/nvm_page_erase_byte_write_ctrl_tb.sv]
// Purpose: Self-checking bench of the non-volatile data controller
// Assumes: Register port answers one cycle after the strobe
// Notes:   Inputs change by non-blocking assignment, at the rising edge or 1 ns after it
`timescale 1ns/1ps
`default_nettype none
`include "nvm_ctrl_params.svh"
module nvm_page_erase_byte_write_ctrl_tb;
    // ---------------------------------------------------------------
    // Signals
    // ---------------------------------------------------------------
    logic                clock_in;
    logic                rst_in;
    logic          [7:0] reg_addr_in;
    logic          [7:0] reg_wdata_in;
    logic                reg_wr_in;
    logic                reg_rd_in;
    logic          [7:0] reg_rdata_out;
    logic          [7:0] code_addr_in;
    logic          [7:0] code_rdata_out;
    logic                cpu_stall_out;
    nvm_ctrl_pkg::byte_t addr_now;
    int                  err_total;
    int                  checked;
    int                  cycles;

    nvm_page_erase_byte_write_ctrl u_nvm_page_erase_byte_write_ctrl (
        .clock_in       (clock_in),
        .rst_in         (rst_in),
        .reg_addr_in    (reg_addr_in),
        .reg_wdata_in   (reg_wdata_in),
        .reg_wr_in      (reg_wr_in),
        .reg_rd_in      (reg_rd_in),
        .reg_rdata_out  (reg_rdata_out),
        .code_addr_in   (code_addr_in),
        .code_rdata_out (code_rdata_out),
        .cpu_stall_out  (cpu_stall_out)
    );

    always #5 clock_in = ~clock_in;

    // ---------------------------------------------------------------
    // Access tasks
    // ---------------------------------------------------------------
    task automatic check(input nvm_ctrl_pkg::byte_t seen,
                         input nvm_ctrl_pkg::byte_t exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        if (err_total == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Strobe stays up so that writes can follow with no gap
    task automatic wr(input nvm_ctrl_pkg::byte_t a,
                      input nvm_ctrl_pkg::byte_t d);
        reg_wr_in    <= 1'b1;
        reg_rd_in    <= 1'b0;
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        @(posedge clock_in);
    endtask

    task automatic idle(input int n);
        reg_wr_in <= 1'b0;
        reg_rd_in <= 1'b0;
        repeat (n) @(posedge clock_in);
    endtask

    task automatic rd(input nvm_ctrl_pkg::byte_t a,
                      input nvm_ctrl_pkg::byte_t exp);
        reg_wr_in   <= 1'b0;
        reg_rd_in   <= 1'b1;
        reg_addr_in <= a;
        @(posedge clock_in);
        reg_rd_in <= 1'b0;
        #1;
        check(reg_rdata_out, exp);
    endtask

    task automatic code_rd(input nvm_ctrl_pkg::byte_t a,
                           input nvm_ctrl_pkg::byte_t exp);
        reg_wr_in    <= 1'b0;
        reg_rd_in    <= 1'b0;
        code_addr_in <= a;
        repeat (2) @(posedge clock_in);
        #1;
        check(code_rdata_out, exp);
    endtask

    task automatic set_addr(input nvm_ctrl_pkg::byte_t a);
        addr_now = a;
        wr(`NVM_OFS_ADDRESS, a);
    endtask

    // Mode 0 unlocks, 1 breaks the key pair, 2 skips the keys;
    // len is the expected stall width, 0 for a refused start
    task automatic op(input nvm_ctrl_pkg::byte_t ctrl, input int gap,
                      input int mode, input nvm_ctrl_pkg::byte_t len);
        int n;
        n = 0;
        if (mode != 2) begin
            wr(`NVM_OFS_KEY, `NVM_KEY_FIRST);
            if (mode == 1) wr(`NVM_OFS_ADDRESS, addr_now);
            wr(`NVM_OFS_KEY, `NVM_KEY_SECOND);
        end
        if (gap > 0) idle(gap);
        wr(`NVM_OFS_CONTROL, ctrl);
        idle(0);
        #1;
        while (cpu_stall_out === 1'b1 && n < 200) begin
            n++;
            @(posedge clock_in);
            #1;
        end
        check(8'(n), len);
    endtask

    task automatic prog(input nvm_ctrl_pkg::byte_t a,
                        input nvm_ctrl_pkg::byte_t d);
        set_addr(a);
        wr(`NVM_OFS_WDATA, d);
        op(8'h40, 0, 0, `NVM_WRITE_CYCLES);
    endtask

    // ---------------------------------------------------------------
    // Hang guard
    // ---------------------------------------------------------------
    always @(posedge clock_in) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_total++;
            final_report();
        end
    end

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        clock_in     = 1'b0;
        rst_in       = 1'b1;
        reg_addr_in  = 8'h00;
        reg_wdata_in = 8'h00;
        reg_wr_in    = 1'b0;
        reg_rd_in    = 1'b0;
        code_addr_in = 8'h00;
        addr_now     = 8'h00;
        err_total    = 0;
        checked      = 0;
        cycles       = 0;
        repeat (4) @(posedge clock_in);
        #1;
        check({7'h00, cpu_stall_out}, 8'h00);
        @(posedge clock_in);
        rst_in <= 1'b0;
        @(posedge clock_in);
        code_rd(8'h00, `NVM_ERASED_BYTE);
        code_rd(8'hFF, `NVM_ERASED_BYTE);
        rd(`NVM_OFS_KEY, 8'h00);
        rd(8'h3C, 8'h00);
        set_addr(8'h45);
        rd(`NVM_OFS_ADDRESS, 8'h45);
        wr(`NVM_OFS_WDATA, 8'hA5);
        rd(`NVM_OFS_WDATA, 8'hA5);
        op(8'h40, 0, 2, 8'h00);
        op(8'h40, 0, 1, 8'h00);
        op(8'h40, 3, 0, 8'h00);
        op(8'h00, 0, 0, 8'h00);
        code_rd(8'h45, `NVM_ERASED_BYTE);
        op(8'h40, 2, 0, `NVM_WRITE_CYCLES);
        rd(`NVM_OFS_CONTROL, 8'h00);
        code_rd(8'h45, 8'hA5);
        prog(8'h3F, 8'h11);
        prog(8'h7F, 8'h22);
        prog(8'h80, 8'h33);
        // Mid-write: control reads busy, address write is held off
        set_addr(8'h01);
        wr(`NVM_OFS_WDATA, 8'h5A);
        wr(`NVM_OFS_KEY, `NVM_KEY_FIRST);
        wr(`NVM_OFS_KEY, `NVM_KEY_SECOND);
        wr(`NVM_OFS_CONTROL, 8'h40);
        wr(`NVM_OFS_ADDRESS, 8'h02);
        rd(`NVM_OFS_CONTROL, 8'h40);
        rd(`NVM_OFS_ADDRESS, 8'h01);
        idle(8);
        code_rd(8'h01, 8'h5A);
        // Erase through an address inside page 1, not its first byte
        set_addr(8'h50);
        op(8'h80, 0, 0, `NVM_ERASE_CYCLES);
        rd(`NVM_OFS_CONTROL, 8'h00);
        rd(`NVM_OFS_ADDRESS, 8'h50);
        code_rd(8'h45, `NVM_ERASED_BYTE);
        code_rd(8'h7F, `NVM_ERASED_BYTE);
        code_rd(8'h3F, 8'h11);
        code_rd(8'h80, 8'h33);
        // Both start bits: erase wins, page 3 through a mid-page address
        prog(8'hFF, 8'h44);
        code_rd(8'hFF, 8'h44);
        set_addr(8'hC5);
        op(8'hC0, 1, 0, `NVM_ERASE_CYCLES);
        rd(`NVM_OFS_WDATA, 8'h44);
        code_rd(8'hFF, `NVM_ERASED_BYTE);
        code_rd(8'h80, 8'h33);
        final_report();
    end
endmodule // nvm_page_erase_byte_write_ctrl_tb
`default_nettype wire
